// ### rtl/ebra_map.vh
// Constants for the external bus ready and hold arbitration block
`ifndef EBRA_MAP_VH
`define EBRA_MAP_VH
`define EBRA_CLK_PERIOD_NS   8
`define EBRA_TCL_HALF_CYC    1
`define EBRA_SYSTEM_CLOCK_OUTPUT_DIV      2'h2
`define EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W          4
`define EBRA_MUX_GAP_TRISTATE_TURNAROUND_WAITSTATE    2
`define EBRA_ADDR_W          24
`define EBRA_DATA_W          16
`endif

// ### rtl/ebra_clkgen.v
// System clock output generator, one pulse per clock-output cycle
`timescale 1ns/1ps
module ebra_clkgen (
    input  wire core_clk,
    input  wire rst_n,
    output reg  system_clock_output,
    output wire system_clock_output_rise
);
    // ------------------------------------------------------------
    // Divide by two
    // ------------------------------------------------------------
    assign system_clock_output_rise = ~system_clock_output;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_clock_output <= 1'b0;
        end else begin
            system_clock_output <= ~system_clock_output;
        end
    end
endmodule // ebra_clkgen

// ### rtl/ebra_wscnt.v
// Waitstate down-counter in clock-output cycles
`timescale 1ns/1ps
`include "ebra_map.vh"
module ebra_wscnt (
    input  wire                    core_clk,
    input  wire                    rst_n,
    input  wire                    tick,
    input  wire                    load,
    input  wire [`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W-1:0] load_val,
    output wire                    zero
);
    reg [`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W-1:0] cnt;
    assign zero = (cnt == {`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W{1'b0}});
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= {`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W{1'b0}};
        end else if (load) begin
            cnt <= load_val;
        end else if (tick && !zero) begin
            cnt <= cnt - 1'b1;
        end
    end
endmodule // ebra_wscnt

// ### rtl/ebra_arbiter.v
// External bus cycle sequencer with ready waitstates and hold arbitration
// Operation
// - Ready sampled high at sampling point adds one ready waitstate
// - Ready sampled low at sampling point ends current bus cycle
// - Programmed cycle length with memory waitstates runs before ready waitstates
// - Command leading edge position depends on read/write delay option
// - Multiplexed modes add a multiplexing waitstate, optional tristate waitstate
// - Gap is two clock-outputs multiplexed with tristate, zero demultiplexed without
// - On hold request, finish running cycle then grant the bus
// - After release, chip selects float to pulled-up high
// - Own bus request never before release complete
// - Regain starts only when hold request goes inactive high
// - After regain, drive outputs again before next external cycle
`timescale 1ns/1ps
`include "ebra_map.vh"
module ebra_arbiter (
    input  wire                    core_clk,
    input  wire                    nrst,
    input  wire                    cyc_req,
    input  wire                    cyc_write,
    input  wire [`EBRA_ADDR_W-1:0] cyc_addr,
    input  wire [`EBRA_DATA_W-1:0] cyc_wdata,
    input  wire [3:0]              cyc_cs_sel,
    output wire                    cyc_ack,
    output reg  [`EBRA_DATA_W-1:0] cyc_rdata,
    input  wire [`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W-1:0] memory_cycle_waitstate_count,
    input  wire                    rw_delay_en,
    input  wire                    ready_en,
    input  wire                    mux_bus_en,
    input  wire                    tristate_turnaround_waitstate,
    input  wire                    own_bus_need,
    input  wire                    ready_n,
    input  wire                    hold_n,
    output reg                     bus_grant_acknowledge_out,
    output reg                     regain_bus_request_out_n,
    output wire                    system_clock_output,
    output reg                     rd_n,
    output reg                     wr_n,
    output reg  [3:0]              chip_select_line_n,
    output reg  [3:0]              chip_select_line_n_oe,
    output reg  [`EBRA_ADDR_W-1:0] addr_out,
    output reg                     addr_oe,
    output reg  [`EBRA_DATA_W-1:0] data_out,
    output reg                     data_oe,
    input  wire [`EBRA_DATA_W-1:0] data_in,
    output wire                    bus_held
);
    // ------------------------------------------------------------
    // Reset release and clock output
    // ------------------------------------------------------------
    reg  [1:0] rst_sync;
    wire       rst_n = rst_sync[1];
    wire       tick;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    ebra_clkgen u_clk (
        .core_clk            (core_clk),
        .rst_n               (rst_n),
        .system_clock_output (system_clock_output),
        .system_clock_output_rise         (tick)
    );

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [8:0] S_IDLE  = 9'h001;
    localparam [8:0] S_ADDR  = 9'h002;
    localparam [8:0] S_DLY   = 9'h004;
    localparam [8:0] S_CMD   = 9'h008;
    localparam [8:0] S_RDY   = 9'h010;
    localparam [8:0] S_MUX   = 9'h020;
    localparam [8:0] S_TTC   = 9'h040;
    localparam [8:0] S_HELD  = 9'h080;
    localparam [8:0] S_REGN  = 9'h100;
    reg  [8:0] state;
    reg  [8:0] next_state;
    reg        ws_load;
    wire       ws_zero;
    reg        hold_q;
    reg        cur_write;
    reg  [3:0] cur_cs;
    reg        cyc_done;
    wire       ws_tick;

    ebra_wscnt u_ws (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (ws_tick),
        .load     (ws_load),
        .load_val (memory_cycle_waitstate_count),
        .zero     (ws_zero)
    );

    assign ws_tick  = tick && (state == S_CMD);
    assign cyc_ack  = cyc_done;
    assign bus_held = (state == S_HELD);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        ws_load    = 1'b0;
        case (state)
            S_IDLE: begin
                if (hold_q) begin
                    next_state = S_HELD;
                end else if (cyc_req) begin
                    next_state = S_ADDR;
                    ws_load    = 1'b1;
                end
            end
            S_ADDR: begin
                next_state = rw_delay_en ? S_DLY : S_CMD;
            end
            S_DLY: begin
                next_state = S_CMD;
            end
            S_CMD: begin
                if (ws_zero) begin
                    next_state = S_RDY;
                end
            end
            S_RDY: begin
                if (!ready_en || !ready_n) begin
                    if (mux_bus_en) begin
                        next_state = S_MUX;
                    end else if (tristate_turnaround_waitstate) begin
                        next_state = S_TTC;
                    end else begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_MUX: begin
                next_state = tristate_turnaround_waitstate ? S_TTC : S_IDLE;
            end
            S_TTC: begin
                next_state = S_IDLE;
            end
            S_HELD: begin
                if (!hold_q) begin
                    next_state = S_REGN;
                end
            end
            S_REGN: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer, stepped on clock-output rising edges
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                     <= S_IDLE;
            hold_q                    <= 1'b0;
            bus_grant_acknowledge_out <= 1'b0;
            regain_bus_request_out_n  <= 1'b1;
            rd_n                      <= 1'b1;
            wr_n                      <= 1'b1;
            chip_select_line_n        <= 4'hF;
            chip_select_line_n_oe     <= 4'hF;
            addr_out                  <= {`EBRA_ADDR_W{1'b0}};
            addr_oe                   <= 1'b1;
            data_out                  <= {`EBRA_DATA_W{1'b0}};
            data_oe                   <= 1'b0;
            cyc_rdata                 <= {`EBRA_DATA_W{1'b0}};
            cur_write                 <= 1'b0;
            cur_cs                    <= 4'hF;
            cyc_done                  <= 1'b0;
        end else begin
            cyc_done <= 1'b0;
            if (tick) begin
                hold_q <= ~hold_n;
                state  <= next_state;
                case (next_state)
                    S_ADDR: begin
                        if (state == S_IDLE) begin
                            addr_out           <= cyc_addr;
                            cur_write          <= cyc_write;
                            cur_cs             <= cyc_cs_sel;
                            chip_select_line_n <= cyc_cs_sel;
                            data_out           <= cyc_wdata;
                            data_oe            <= cyc_write;
                        end
                    end
                    S_CMD: begin
                        rd_n               <= cur_write;
                        wr_n               <= ~cur_write;
                        chip_select_line_n <= cur_cs;
                    end
                    S_HELD: begin
                        if (state == S_IDLE) begin
                            bus_grant_acknowledge_out <= 1'b1;
                            chip_select_line_n_oe     <= 4'h0;
                            chip_select_line_n        <= 4'hF;
                            addr_oe                   <= 1'b0;
                            data_oe                   <= 1'b0;
                        end else begin
                            regain_bus_request_out_n  <= ~own_bus_need;
                        end
                    end
                    S_REGN: begin
                        bus_grant_acknowledge_out <= 1'b0;
                        regain_bus_request_out_n  <= 1'b1;
                    end
                    S_IDLE: begin
                        if (state == S_REGN) begin
                            chip_select_line_n_oe <= 4'hF;
                            addr_oe               <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
                if (state == S_RDY && next_state != S_RDY) begin
                    rd_n               <= 1'b1;
                    wr_n               <= 1'b1;
                    chip_select_line_n <= 4'hF;
                    data_oe            <= 1'b0;
                    cyc_done           <= 1'b1;
                    if (!cur_write) begin
                        cyc_rdata <= data_in;
                    end
                end
            end
        end
    end
endmodule // ebra_arbiter

// ### testbench/ebra_props.sv
// Checker for ready waitstates and bus hold arbitration
`timescale 1ns/1ps
module ebra_props (
    input wire       core_clk,
    input wire       nrst,
    input wire       ready_en,
    input wire       ready_n,
    input wire       hold_n,
    input wire       rd_n,
    input wire       wr_n,
    input wire       cyc_ack,
    input wire       bus_held,
    input wire       bus_grant_acknowledge_out,
    input wire       regain_bus_request_out_n,
    input wire       system_clock_output,
    input wire [3:0] chip_select_line_n_oe,
    input wire       addr_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire cmd  = !(rd_n && wr_n);
    wire tick = !system_clock_output;
    sequence s_regain; $fell(bus_grant_acknowledge_out); endsequence
    sequence s_redrive; chip_select_line_n_oe == 4'hF && addr_oe; endsequence
    chk_ready_wait: assert property (ready_en && cmd && tick && ready_n |=> cmd)
        else $error("command ended with ready high");
    chk_ready_end: assert property (cyc_ack && ready_en |-> !cmd && !$past(ready_n))
        else $error("cycle end without ready low");
    chk_ack_pulse: assert property (cyc_ack |=> !cyc_ack)
        else $error("ack longer than one cycle");
    chk_grant_idle: assert property ($rose(bus_grant_acknowledge_out) |-> !cmd && !hold_n)
        else $error("grant during cycle or without hold");
    chk_cs_float: assert property (bus_grant_acknowledge_out |-> !chip_select_line_n_oe && !addr_oe)
        else $error("outputs driven while granted");
    chk_regain_bus_request_out_after: assert property ($fell(regain_bus_request_out_n) |-> bus_grant_acknowledge_out)
        else $error("bus request before release");
    chk_regain_hold: assert property (s_regain |-> $past(hold_n))
        else $error("regain without hold inactive");
    chk_regain_drive: assert property (s_regain |-> ##[1:4] s_redrive)
        else $error("outputs not driven after regain");
    chk_edge_step: assert property ($changed(bus_grant_acknowledge_out) |-> !$past(system_clock_output))
        else $error("grant changed off clock-output edge");
    chk_held_quiet: assert property (bus_held |-> !cmd && !cyc_ack)
        else $error("cycle while bus held");
endmodule // ebra_props
bind ebra_arbiter ebra_props u_props (.core_clk, .nrst, .ready_en, .ready_n, .hold_n, .rd_n,
    .wr_n, .cyc_ack, .bus_held, .bus_grant_acknowledge_out, .regain_bus_request_out_n,
    .system_clock_output, .chip_select_line_n_oe, .addr_oe);

// ### testbench/ebra_mem_model.sv
// Ready and read data responder for the external bus
`timescale 1ns/1ps
module ebra_mem_model (
    input  wire        core_clk,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire [23:0] addr_out,
    input  wire [7:0]  lat,
    output reg         ready_n = 1'h1,
    output reg  [15:0] data_in = 16'h0000
);
    reg [7:0] cnt = 8'h00;
    always @(posedge core_clk) begin
        cnt     <= (rd_n && wr_n) ? 8'h00 : cnt + 8'h01;
        ready_n <= (rd_n && wr_n) || (cnt < lat);
        data_in <= !rd_n ? addr_out[15:0] : ~data_in;
    end
endmodule // ebra_mem_model

// ### testbench/ebra_arbiter_tb.sv
// Self-checking bench for the external bus ready and hold arbiter
`timescale 1ns/1ps
`include "ebra_map.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module ebra_arbiter_tb;
    reg                     core_clk = 0, nrst = 0, cyc_req = 0, cyc_write = 0;
    reg  [`EBRA_ADDR_W-1:0] cyc_addr = 0;
    reg  [`EBRA_DATA_W-1:0] cyc_wdata = 16'h5A3C;
    reg  [3:0]              cyc_cs_sel = 4'hE;
    reg  [`EBRA_MEMORY_CYCLE_WAITSTATE_COUNT_W-1:0] memory_cycle_waitstate_count = 0;
    reg                     rw_delay_en = 0, ready_en = 1, mux_bus_en = 0, hold_n = 1;
    reg                     tristate_turnaround_waitstate = 0, own_bus_need = 0;
    reg  [7:0]              lat = 0;
    wire                    ready_n, cyc_ack, bus_grant_acknowledge_out, system_clock_output;
    wire                    regain_bus_request_out_n, rd_n, wr_n, addr_oe, data_oe, bus_held;
    wire [`EBRA_DATA_W-1:0] cyc_rdata, data_out, data_in;
    wire [`EBRA_ADDR_W-1:0] addr_out;
    wire [3:0]              chip_select_line_n, chip_select_line_n_oe;
    integer error_cnt = 0, n_compared = 0, n, cmd_at, w, acks = 0, cyc = 0, i;
    integer cm[5] = '{0, 3, 0, 0, 1};
    integer cd[5] = '{0, 0, 1, 0, 1};
    integer cl[5] = '{0, 0, 0, 4, 20};
    ebra_arbiter dut (.*);
    ebra_mem_model u_mem (.core_clk, .rd_n, .wr_n, .addr_out, .lat, .ready_n, .data_in);
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (cyc_ack === 1'b1) acks <= acks + 1;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            conclude;
        end
    end
    task conclude;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task align;
        begin
            do begin @(posedge core_clk); #1; end while (system_clock_output !== 1'b1);
            @(posedge core_clk);
            cyc_req <= 1'h1;
        end
    endtask
    task wack;
        begin
            n = 0;
            cmd_at = 0;
            do begin
                @(posedge core_clk); #1; n++;
                if (cmd_at == 0 && !(rd_n && wr_n)) cmd_at = n;
            end while (cyc_ack !== 1'b1 && n < 200);
        end
    endtask
    task wgrant(input v);
        begin
            n = 0;
            while (bus_grant_acknowledge_out !== v && n < 50) begin
                @(posedge core_clk); #1; n++;
            end
            `CHK(bus_grant_acknowledge_out, v)
        end
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge core_clk);
        for (i = 0; i < 5; i++) begin
            @(posedge core_clk);
            memory_cycle_waitstate_count <= cm[i];
            rw_delay_en <= cd[i];
            lat         <= cl[i];
            ready_en    <= (i != 4);
            cyc_write   <= i[0];
            cyc_addr    <= 24'h0100A5 + i;
            align;
            wack;
            w = 0;
            while (ready_en && cl[i] > 2 * (cm[i] + w) + 2) w++;
            `CHK(cmd_at, 3 + 2 * cd[i])
            `CHK(n, 2 * (3 + cm[i] + cd[i] + w) + 1)
            if (!cyc_write) `CHK(cyc_rdata, cyc_addr[15:0])
            if (cyc_write) `CHK(data_out, cyc_wdata)
            `CHK(addr_out, cyc_addr)
            `CHK({data_oe, chip_select_line_n}, 5'h0F)
            @(posedge core_clk);
            cyc_req <= 1'h0;
            $display("cycle test %0d done", i);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {mux_bus_en, tristate_turnaround_waitstate} <= i[1:0];
            {memory_cycle_waitstate_count, rw_delay_en, ready_en, lat} <= 14'h0100;
            align;
            wack;
            wack;
            `CHK(n, 2 * (4 + ((i == 3) ? `EBRA_MUX_GAP_TRISTATE_TURNAROUND_WAITSTATE : (i != 0))))
            @(posedge core_clk);
            cyc_req <= 1'h0;
            $display("gap test %0d done", i);
        end
        @(posedge core_clk);
        {mux_bus_en, tristate_turnaround_waitstate, lat} <= 10'h008;
        align;
        repeat (3) @(posedge core_clk);
        hold_n <= 1'h0;
        wack;
        `CHK(bus_grant_acknowledge_out, 1'h0)
        @(posedge core_clk);
        cyc_req <= 1'h0;
        wgrant(1'h1);
        `CHK(chip_select_line_n_oe, 4'h0)
        `CHK({addr_oe, chip_select_line_n, bus_held}, 6'h1F)
        @(posedge core_clk);
        {cyc_req, own_bus_need} <= 2'h3;
        w = acks;
        repeat (20) @(posedge core_clk);
        #1;
        `CHK(acks, w)
        `CHK(regain_bus_request_out_n, 1'h0)
        @(posedge core_clk);
        hold_n <= 1'h1;
        wgrant(1'h0);
        wack;
        `CHK(cyc_ack, 1'h1)
        `CHK({addr_oe, chip_select_line_n_oe}, 5'h1F)
        @(posedge core_clk);
        {cyc_req, own_bus_need, hold_n} <= 3'h0;
        wgrant(1'h1);
        `CHK(regain_bus_request_out_n, 1'h1)
        @(posedge core_clk);
        hold_n <= 1'h1;
        wgrant(1'h0);
        $display("hold test done");
        conclude;
    end
endmodule // ebra_arbiter_tb
